// *** bfc_defs.svh ***
`ifndef BFC_DEFS_SVH
`define BFC_DEFS_SVH

// ****************************************************************
// function codes
// ****************************************************************
`define BFC_FID_CFG       8'hf0
`define BFC_FID_IRQ_CLR   8'hf1
`define BFC_FID_IDLE      8'hf2
`define BFC_FID_PIN_WR    8'hf4
`define BFC_FID_PIN_RD    8'hf5
`define BFC_FID_PIN_EN    8'hf6
`define BFC_FID_PIN_DRV   8'hf7

// ****************************************************************
// link setup and pin byte layout and reset values
// ****************************************************************
`define BFC_CFG_ORDER_BIT 5
`define BFC_CFG_SHAPE_HI  3
`define BFC_CFG_SHAPE_LO  2
`define BFC_CFG_RATE_HI   1
`define BFC_CFG_RATE_LO   0
`define BFC_CFG_USED_MASK 8'h2f
`define BFC_CFG_RESET     8'h00
`define BFC_PIN_BITS_MASK 4'hf
`define BFC_PIN_EN_RESET  4'h0
`define BFC_PIN_LAT_RESET 4'h0
`define BFC_PIN_DRV_RESET 8'h00
`define BFC_LINE3_BIT     3

// ****************************************************************
// timing: clock and serial clock rates
// ****************************************************************
`define BFC_CLK_KHZ       25000
`define BFC_RATE0_KHZ     1843
`define BFC_RATE1_KHZ     461
`define BFC_RATE2_KHZ     115
`define BFC_RATE3_KHZ     58
`define BFC_EXT_DIV0      4
`define BFC_EXT_DIV1      16
`define BFC_EXT_DIV2      64
`define BFC_EXT_DIV3      128
`define BFC_DIV_W         9
`define BFC_STRONG_CYCLES 2

`endif

// *** bfc_pkg.sv ***
package bfc_pkg;

  typedef enum logic [2:0] {
    BFC_ST_IDLE,
    BFC_ST_FID,
    BFC_ST_DATA,
    BFC_ST_EXEC,
    BFC_ST_SLEEP
  } bfc_state_t;

  // order gives the two-bit drive codes 00..11
  typedef enum logic [1:0] {
    BFC_DRV_QUASI,
    BFC_DRV_PUSH,
    BFC_DRV_INPUT,
    BFC_DRV_OPEN
  } bfc_drive_t;

  typedef struct packed {
    bfc_state_t  st;
    logic [7:0]  fid;
    logic [7:0]  data;
    logic [1:0]  nbytes;
    logic [7:0]  cfg;
    logic [3:0]  gpio_en;
    logic [3:0]  latch;
    logic [7:0]  drive;
    logic        irq;
    logic        buf_wr;
    logic [7:0]  buf_data;
    logic [8:0]  div_cnt;
    logic        tick;
  } bfc_core_t;

  typedef struct packed {
    logic        prev_latch;
    logic [1:0]  strong_cnt;
  } bfc_cell_t;

endpackage

// *** bfc_pin_cell.sv ***
`timescale 1ns/10ps
`include "bfc_defs.svh"

module bfc_pin_cell (
  input  wire logic               clk_in,
  input  wire logic               resetn_in,
  input  wire logic               gpio_en_in,
  input  wire logic               latch_in,
  input  wire bfc_pkg::bfc_drive_t drive_in,
  input  wire logic               spi_sel_n_in,
  output logic                    pin_out,
  output logic                    pin_oe_out
);
  import bfc_pkg::*;

  bfc_cell_t cell_reg;
  bfc_cell_t cell_next;

  // ****************************************************************
  // strong pull-up pulse on a low-to-high latch change
  // ****************************************************************
  always_comb begin
    cell_next = cell_reg;
    cell_next.prev_latch = latch_in;
    if (gpio_en_in && latch_in && !cell_reg.prev_latch) begin
      cell_next.strong_cnt = 2'(`BFC_STRONG_CYCLES);
    end else if (cell_reg.strong_cnt != 2'h0) begin
      cell_next.strong_cnt = cell_reg.strong_cnt - 2'h1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cell_reg <= '0;
    end else begin
      cell_reg <= cell_next;
    end
  end

  // ****************************************************************
  // pin drive
  // ****************************************************************
  // weak pull-ups of the quasi type sit outside; only strong drive is modelled here
  always_comb begin
    pin_out    = latch_in;
    pin_oe_out = 1'b0;
    if (!gpio_en_in) begin
      pin_out    = spi_sel_n_in; // R14
      pin_oe_out = 1'b1;
    end else begin
      unique case (drive_in) // R17
        BFC_DRV_QUASI: pin_oe_out = !latch_in || (cell_reg.strong_cnt != 2'h0);
        BFC_DRV_PUSH:  pin_oe_out = 1'b1;
        BFC_DRV_INPUT: pin_oe_out = 1'b0;
        BFC_DRV_OPEN:  pin_oe_out = !latch_in;
      endcase
    end
  end

endmodule // bfc_pin_cell

// *** bfc_cmd_core.sv ***
// Overview of operation
// R1 - f0h plus exactly one byte loads the serial link setup byte.
// R2 - setup bit 5: 0 sends msb first, 1 sends lsb first.
// R3 - setup bits 3:2 pick clock idle level and sampling edge.
// R4 - setup bits 1:0 pick serial clock rate, per oscillator variant.
// R5 - interrupt pin goes low on every finished transfer and stays low.
// R6 - f1h releases the interrupt pin high.
// R7 - a polling master may skip the interrupt clear.
// R8 - f2h puts the device into low-power idle.
// R9 - idle ends when the device's own address is seen.
// R10 - f4h byte bits 3:0 set levels of general-purpose select lines.
// R11 - f5h samples the lines into the buffer, returning nothing.
// R12 - sampled bits of non general-purpose lines are undefined.
// R13 - master reads one buffer byte, and resamples before each read.
// R14 - after reset all select lines are active-low slave selects.
// R15 - f6h bit n makes line n general-purpose, 0 returns it.
// R16 - lines newly made general-purpose take quasi-bidirectional drive.
// R17 - f7h bits 2n+1:2n set drive type of line n.
// R18 - on the external-clock variant line 3 bits have no effect.
// R19 - each write message is address, one function code, then data.
// R20 - after stop, no bus traffic is acknowledged until the function ends.
// R21 - reserved setup bits and pin byte bits 7:4 are ignored.
// R22 - setup byte resets to zero: msb first, mode 00, fastest rate.
`timescale 1ns/10ps
`include "bfc_defs.svh"

module bfc_cmd_core #(
  parameter bit EXT_CLK = 1'b0
) (
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // byte front end of the bus slave
  input  wire logic        addr_hit_in,
  input  wire logic        rw_in,
  input  wire logic        byte_valid_in,
  input  wire logic [7:0]  byte_in,
  input  wire logic        stop_in,
  output logic             busy_out,
  // serial link engine
  input  wire logic        spi_done_in,
  input  wire logic [3:0]  spi_sel_n_in,
  output logic             lsb_first_out,
  output logic [1:0]       clock_shape_select_out,
  output logic [1:0]       clock_rate_select_out,
  output logic             sck_tick_out,
  // data buffer write port
  output logic             buf_wr_out,
  output logic [7:0]       buf_data_out,
  // select lines
  input  wire logic [3:0]  sel_line_in,
  output logic [3:0]       sel_line_out,
  output logic [3:0]       sel_line_oe_out,
  // misc
  output logic             irq_n_out,
  output logic             low_power_out
);
  import bfc_pkg::*;

  // ****************************************************************
  // variant constants
  // ****************************************************************
  localparam int DIV0 = EXT_CLK ? `BFC_EXT_DIV0 : (`BFC_CLK_KHZ / `BFC_RATE0_KHZ);
  localparam int DIV1 = EXT_CLK ? `BFC_EXT_DIV1 : (`BFC_CLK_KHZ / `BFC_RATE1_KHZ);
  localparam int DIV2 = EXT_CLK ? `BFC_EXT_DIV2 : (`BFC_CLK_KHZ / `BFC_RATE2_KHZ);
  localparam int DIV3 = EXT_CLK ? `BFC_EXT_DIV3 : (`BFC_CLK_KHZ / `BFC_RATE3_KHZ);
  localparam logic [3:0] LINE_MASK =
    EXT_CLK ? (`BFC_PIN_BITS_MASK & ~(4'h1 << `BFC_LINE3_BIT)) : `BFC_PIN_BITS_MASK; // R18

  bfc_core_t core_reg;
  bfc_core_t core_next;

  logic              one_byte;
  logic [3:0]        new_en;
  logic [`BFC_DIV_W-1:0] div_end;

  assign one_byte = (core_reg.nbytes == 2'h1);
  assign new_en   = core_reg.data[3:0] & LINE_MASK; // R21

  // ****************************************************************
  // serial clock rate enable
  // ****************************************************************
  always_comb begin
    unique case (core_reg.cfg[`BFC_CFG_RATE_HI:`BFC_CFG_RATE_LO]) // R4
      2'h0: div_end = `BFC_DIV_W'(DIV0 - 1);
      2'h1: div_end = `BFC_DIV_W'(DIV1 - 1);
      2'h2: div_end = `BFC_DIV_W'(DIV2 - 1);
      2'h3: div_end = `BFC_DIV_W'(DIV3 - 1);
    endcase
  end

  // ****************************************************************
  // command sequencing
  // ****************************************************************
  always_comb begin
    core_next        = core_reg;
    core_next.buf_wr = 1'b0;
    core_next.tick   = 1'b0;

    unique case (core_reg.st)
      BFC_ST_IDLE: begin
        if (addr_hit_in && !rw_in) begin
          core_next.st = BFC_ST_FID;
        end
      end
      BFC_ST_FID: begin
        if (addr_hit_in) begin
          core_next.st = rw_in ? BFC_ST_IDLE : BFC_ST_FID;
        end else if (stop_in) begin
          core_next.st = BFC_ST_IDLE;
        end else if (byte_valid_in) begin
          core_next.fid    = byte_in; // R19
          core_next.nbytes = 2'h0;
          core_next.st     = BFC_ST_DATA;
        end
      end
      BFC_ST_DATA: begin
        if (addr_hit_in) begin
          core_next.st = rw_in ? BFC_ST_IDLE : BFC_ST_FID;
        end else if (stop_in) begin
          core_next.st = BFC_ST_EXEC; // R20
        end else if (byte_valid_in) begin
          // keep the first data byte; count saturates so a long message shows as "more than one"
          if (core_reg.nbytes == 2'h0) begin
            core_next.data = byte_in;
          end
          if (core_reg.nbytes != 2'h2) begin
            core_next.nbytes = core_reg.nbytes + 2'h1;
          end
        end
      end
      BFC_ST_EXEC: begin
        core_next.st = BFC_ST_IDLE;
        unique case (core_reg.fid)
          `BFC_FID_CFG: begin
            if (one_byte) begin
              core_next.cfg = core_reg.data & `BFC_CFG_USED_MASK; // R1 R21
            end
          end
          `BFC_FID_IRQ_CLR: begin
            core_next.irq = 1'b0; // R6
          end
          `BFC_FID_IDLE: begin
            core_next.st = BFC_ST_SLEEP; // R8
          end
          `BFC_FID_PIN_WR: begin
            if (one_byte) begin
              core_next.latch = (core_reg.latch & ~(core_reg.gpio_en & LINE_MASK))
                              | (core_reg.data[3:0] & core_reg.gpio_en & LINE_MASK); // R10
            end
          end
          `BFC_FID_PIN_RD: begin
            core_next.buf_wr   = 1'b1; // R11
            core_next.buf_data = {4'h0, sel_line_in & LINE_MASK}; // R12
          end
          `BFC_FID_PIN_EN: begin
            if (one_byte) begin
              core_next.gpio_en = new_en; // R15
              for (int i = 0; i < 4; i++) begin
                if (new_en[i] && !core_reg.gpio_en[i]) begin
                  core_next.drive[2*i +: 2] = BFC_DRV_QUASI; // R16
                end
              end
            end
          end
          `BFC_FID_PIN_DRV: begin
            if (one_byte) begin
              for (int i = 0; i < 4; i++) begin
                if (LINE_MASK[i]) begin
                  core_next.drive[2*i +: 2] = core_reg.data[2*i +: 2]; // R17
                end
              end
            end
          end
          default: begin
            // transfer codes are carried out by the link engine
          end
        endcase
      end
      BFC_ST_SLEEP: begin
        if (addr_hit_in) begin
          core_next.st = rw_in ? BFC_ST_IDLE : BFC_ST_FID; // R9
        end
      end
      default: core_next.st = BFC_ST_IDLE;
    endcase

    // divider stops in idle to save power; keyed on the next state so no tick leaks into idle
    if (core_next.st == BFC_ST_SLEEP) begin
      core_next.div_cnt = '0;
    end else if (core_reg.div_cnt >= div_end) begin
      core_next.div_cnt = '0;
      core_next.tick    = 1'b1;
    end else begin
      core_next.div_cnt = core_reg.div_cnt + `BFC_DIV_W'(1);
    end

    // a finished transfer wins over a clear in the same cycle
    if (spi_done_in) begin
      core_next.irq = 1'b1; // R5
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      core_reg         <= '0;
      core_reg.st      <= BFC_ST_IDLE;
      core_reg.cfg     <= `BFC_CFG_RESET; // R22
      core_reg.gpio_en <= `BFC_PIN_EN_RESET; // R14
      core_reg.latch   <= `BFC_PIN_LAT_RESET;
      core_reg.drive   <= `BFC_PIN_DRV_RESET;
    end else begin
      core_reg <= core_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign busy_out               = (core_reg.st == BFC_ST_EXEC); // R20
  assign lsb_first_out          = core_reg.cfg[`BFC_CFG_ORDER_BIT]; // R2
  assign clock_shape_select_out = core_reg.cfg[`BFC_CFG_SHAPE_HI:`BFC_CFG_SHAPE_LO]; // R3
  assign clock_rate_select_out  = core_reg.cfg[`BFC_CFG_RATE_HI:`BFC_CFG_RATE_LO];
  assign sck_tick_out           = core_reg.tick;
  assign buf_wr_out             = core_reg.buf_wr;
  assign buf_data_out           = core_reg.buf_data;
  assign irq_n_out              = !core_reg.irq;
  assign low_power_out          = (core_reg.st == BFC_ST_SLEEP);

  // ****************************************************************
  // select line cells
  // ****************************************************************
  // absent line 3 stays a plain slave select, never a general-purpose pin
  for (genvar g = 0; g < 4; g++) begin : g_line
    bfc_pin_cell u_cell (
      .clk_in       (clk_in),
      .resetn_in    (resetn_in),
      .gpio_en_in   (core_reg.gpio_en[g] & LINE_MASK[g]),
      .latch_in     (core_reg.latch[g]),
      .drive_in     (bfc_drive_t'(core_reg.drive[2*g +: 2])),
      .spi_sel_n_in (spi_sel_n_in[g]),
      .pin_out      (sel_line_out[g]),
      .pin_oe_out   (sel_line_oe_out[g])
    );
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_exec(logic [7:0] code);
    core_reg.st == BFC_ST_EXEC && core_reg.fid == code;
  endsequence

  sequence s_cfg_msg;
    core_reg.st == BFC_ST_DATA && stop_in && !addr_hit_in && one_byte
      && core_reg.fid == `BFC_FID_CFG ##1 s_exec(`BFC_FID_CFG);
  endsequence

  property p_cfg_apply;
    s_cfg_msg |=> lsb_first_out == $past(core_reg.data[`BFC_CFG_ORDER_BIT])
      && clock_shape_select_out == $past(core_reg.data[3:2])
      && clock_rate_select_out == $past(core_reg.data[1:0]);
  endproperty
  a_cfg_apply: assert property (p_cfg_apply) else $error("setup byte not applied"); // R1

  property p_irq_set;
    spi_done_in |=> !irq_n_out;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("interrupt not raised"); // R5

  property p_irq_hold;
    !irq_n_out && !(core_reg.st == BFC_ST_EXEC && core_reg.fid == `BFC_FID_IRQ_CLR) |=> !irq_n_out;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped early"); // R5

  property p_irq_clr;
    s_exec(`BFC_FID_IRQ_CLR) ##0 !spi_done_in |=> irq_n_out;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("interrupt not cleared"); // R6

  property p_idle_enter;
    s_exec(`BFC_FID_IDLE) |=> low_power_out && !sck_tick_out;
  endproperty
  a_idle_enter: assert property (p_idle_enter) else $error("idle not entered"); // R8

  property p_idle_exit;
    low_power_out && addr_hit_in |=> !low_power_out;
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle not left"); // R9

  property p_pin_sample;
    s_exec(`BFC_FID_PIN_RD) |=> buf_wr_out && buf_data_out[3:0] == ($past(sel_line_in) & LINE_MASK);
  endproperty
  a_pin_sample: assert property (p_pin_sample) else $error("pin sample wrong"); // R11

  property p_sel_default;
    !core_reg.gpio_en[0] |-> sel_line_oe_out[0] && sel_line_out[0] == spi_sel_n_in[0];
  endproperty
  a_sel_default: assert property (p_sel_default) else $error("select line not driven"); // R14

  property p_busy_after_stop;
    core_reg.st == BFC_ST_DATA && stop_in && !addr_hit_in |=> busy_out ##1 !busy_out;
  endproperty
  a_busy_after_stop: assert property (p_busy_after_stop) else $error("busy window wrong"); // R20

  sequence s_one_byte_exec(logic [7:0] code);
    s_exec(code) ##0 one_byte;
  endsequence

  property p_pin_write;
    s_one_byte_exec(`BFC_FID_PIN_WR) |=>
      ((core_reg.latch ^ $past(core_reg.data[3:0])) & $past(core_reg.gpio_en) & LINE_MASK) == 4'h0
      && ((core_reg.latch ^ $past(core_reg.latch)) & ~($past(core_reg.gpio_en) & LINE_MASK)) == 4'h0;
  endproperty
  a_pin_write: assert property (p_pin_write) else $error("pin levels not written"); // R10

  property p_pin_enable;
    s_one_byte_exec(`BFC_FID_PIN_EN) |=> core_reg.gpio_en == ($past(core_reg.data[3:0]) & LINE_MASK);
  endproperty
  a_pin_enable: assert property (p_pin_enable) else $error("pin enable not applied"); // R15

  property p_new_quasi;
    s_one_byte_exec(`BFC_FID_PIN_EN) ##0 (new_en[0] && !core_reg.gpio_en[0])
      |=> bfc_drive_t'(core_reg.drive[1:0]) == BFC_DRV_QUASI;
  endproperty
  a_new_quasi: assert property (p_new_quasi) else $error("new pin not quasi"); // R16

  property p_pin_drive;
    s_one_byte_exec(`BFC_FID_PIN_DRV) |=> core_reg.drive[1:0] == $past(core_reg.data[1:0]);
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("drive type not applied"); // R17

  property p_cfg_reserved;
    (core_reg.cfg & ~`BFC_CFG_USED_MASK) == 8'h00;
  endproperty
  a_cfg_reserved: assert property (p_cfg_reserved) else $error("reserved setup bit kept"); // R21

  property p_line3_absent;
    (core_reg.gpio_en & ~LINE_MASK) == 4'h0 && (buf_data_out[3:0] & ~LINE_MASK) == 4'h0;
  endproperty
  a_line3_absent: assert property (p_line3_absent) else $error("absent line used"); // R18

  property p_sleep_quiet;
    low_power_out |-> !sck_tick_out;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("rate tick in idle"); // R8

endmodule // bfc_cmd_core

// *** bfc_host_model.sv ***
`timescale 1ns/10ps

// ************************************
// bus master byte model
// ************************************
module bfc_host_model (
  input  wire logic       clk_in,
  output logic            addr_hit_out,
  output logic            rw_out,
  output logic            byte_valid_out,
  output logic [7:0]      byte_out,
  output logic            stop_out
);

  initial begin
    addr_hit_out   = 1'b0;
    rw_out         = 1'b0;
    byte_valid_out = 1'b0;
    byte_out       = 8'h00;
    stop_out       = 1'b0;
  end

  // address, then function code, then data, then stop
  task automatic message(input logic rd, input int nb, input logic [23:0] by);
    @(negedge clk_in);
    addr_hit_out = 1'b1;
    rw_out       = rd;
    for (int i = 0; i < nb; i++) begin
      @(negedge clk_in);
      addr_hit_out   = 1'b0;
      byte_valid_out = 1'b1;
      byte_out       = by[8*i+:8];
    end
    @(negedge clk_in);
    addr_hit_out   = 1'b0;
    byte_valid_out = 1'b0;
    // a released data line keeps no old value, so show its inverse
    byte_out       = ~byte_out;
    stop_out       = 1'b1;
    @(negedge clk_in);
    stop_out       = 1'b0;
  endtask

endmodule // bfc_host_model

// *** tb_bridge_function_commands.sv ***
`timescale 1ns/10ps

module tb_bridge_function_commands;
  import bfc_pkg::*;

  logic       clk_in;
  logic       resetn_in;
  logic       addr_hit, rw, byte_valid, stop;
  logic [7:0] byte_d;
  logic       busy_out, spi_done_in, lsb_first_out, sck_tick_out, buf_wr_out;
  logic [3:0] spi_sel_n_in, sel_line_in, sel_line_out, sel_line_oe_out, ext_lvl;
  logic [1:0] clock_shape_select_out, clock_rate_select_out;
  logic [7:0] buf_data_out, b, m_cfg;
  logic       irq_n_out, low_power_out, m_irq, m_idle;
  logic [3:0] m_en, m_lat, exp_pin;
  logic [1:0] m_drv [4];
  int         error_cnt, samples_checked, seed_dummy;

  // ************************************
  // clock, pins and instances
  // ************************************
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // undriven lines follow the external level (pull-up or another device)
  assign sel_line_in = (sel_line_oe_out & sel_line_out) | (~sel_line_oe_out & ext_lvl);

  bfc_host_model host (
    .clk_in         (clk_in),
    .addr_hit_out   (addr_hit),
    .rw_out         (rw),
    .byte_valid_out (byte_valid),
    .byte_out       (byte_d),
    .stop_out       (stop)
  );

  bfc_cmd_core #(.EXT_CLK(1'b0)) uut (
    .clk_in                 (clk_in),
    .resetn_in              (resetn_in),
    .addr_hit_in            (addr_hit),
    .rw_in                  (rw),
    .byte_valid_in          (byte_valid),
    .byte_in                (byte_d),
    .stop_in                (stop),
    .busy_out               (busy_out),
    .spi_done_in            (spi_done_in),
    .spi_sel_n_in           (spi_sel_n_in),
    .lsb_first_out          (lsb_first_out),
    .clock_shape_select_out (clock_shape_select_out),
    .clock_rate_select_out  (clock_rate_select_out),
    .sck_tick_out           (sck_tick_out),
    .buf_wr_out             (buf_wr_out),
    .buf_data_out           (buf_data_out),
    .sel_line_in            (sel_line_in),
    .sel_line_out           (sel_line_out),
    .sel_line_oe_out        (sel_line_oe_out),
    .irq_n_out              (irq_n_out),
    .low_power_out          (low_power_out)
  );

  // ************************************
  // model and checking tasks
  // ************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // quasi drive is only checked once its strong pull-up window is over
  function automatic logic f_oe(input int n);
    if (!m_en[n]) return 1'b1;
    if (m_drv[n] == 2'h1) return 1'b1;
    if (m_drv[n] == 2'h2) return 1'b0;
    return !m_lat[n];
  endfunction

  task automatic compare_all;
    check(lsb_first_out, m_cfg[5]);
    check(clock_shape_select_out, m_cfg[3:2]);
    check(clock_rate_select_out, m_cfg[1:0]);
    check(irq_n_out, !m_irq);
    check(low_power_out, m_idle);
    for (int n = 0; n < 4; n++) begin
      check(sel_line_oe_out[n], f_oe(n));
      if (!m_en[n]) check(sel_line_out[n], spi_sel_n_in[n]);
      else if (f_oe(n)) check(sel_line_out[n], m_lat[n]);
    end
  endtask

  task automatic cmd(input int nb, input logic [23:0] by);
    host.message(1'b0, nb, by);
    check(busy_out, 1'b1);
    @(negedge clk_in);
    check(busy_out, 1'b0);
  endtask

  task automatic spi_pulse;
    @(negedge clk_in);
    spi_done_in = 1'b1;
    @(negedge clk_in);
    spi_done_in = 1'b0;
    m_irq = 1'b1;
  endtask

  // rate codes 0..3 give 1843, 461, 115 and 58 kHz from the 25 MHz clock
  function automatic int f_div(input int r);
    return 25000 / (r == 0 ? 1843 : (r == 1 ? 461 : (r == 2 ? 115 : 58)));
  endfunction

  // counts clocks from one rate tick to the next; gives up after 500
  task automatic tick_period(input int exp);
    int n;
    n = 0;
    while (!sck_tick_out && n < 500) begin
      @(negedge clk_in);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (!sck_tick_out && n < 500);
    check(n, exp);
  endtask

  task automatic finish_test;
    $display("checked %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ************************************
  // tests
  // ************************************
  initial begin
    #800000;
    error_cnt++;
    $display("watchdog expired");
    finish_test();
  end

  initial begin
    error_cnt = 0;
    samples_checked = 0;
    seed_dummy = $urandom(65);
    resetn_in = 1'b0;
    spi_done_in = 1'b0;
    spi_sel_n_in = 4'($urandom);
    ext_lvl = 4'hf;
    m_cfg = 8'h00;
    m_irq = 1'b0;
    m_idle = 1'b0;
    m_en = 4'h0;
    m_lat = 4'h0;
    for (int n = 0; n < 4; n++) m_drv[n] = 2'h0;
    repeat (4) @(negedge clk_in);
    resetn_in = 1'b1;
    compare_all();
    $display("test reset done");

    for (int i = 0; i < 16; i++) begin
      b = 8'($urandom);
      b[3:0] = i[3:0];
      cmd(2, {8'h00, b, 8'hf0});
      m_cfg = b & 8'h2f;
      compare_all();
    end
    cmd(3, {8'h55, 8'h03, 8'hf0});
    compare_all();
    cmd(1, {16'h0000, 8'hf0});
    compare_all();
    for (int r = 3; r >= 0; r--) begin
      cmd(2, {8'h00, 6'h00, r[1:0], 8'hf0});
      m_cfg = {6'h00, r[1:0]};
      compare_all();
      tick_period(f_div(r));
    end
    $display("test link setup done");

    spi_pulse();
    repeat (5) @(negedge clk_in);
    compare_all();
    cmd(1, {16'h0000, 8'hf1});
    m_irq = 1'b0;
    compare_all();
    spi_pulse();
    cmd(1, {16'h0000, 8'h10});
    compare_all();
    cmd(1, {16'h0000, 8'hf1});
    m_irq = 1'b0;
    compare_all();
    $display("test interrupt done");

    cmd(1, {16'h0000, 8'hf2});
    m_idle = 1'b1;
    repeat (20) begin
      @(negedge clk_in);
      check(sck_tick_out, 1'b0);
    end
    compare_all();
    host.message(1'b0, 0, 24'h000000);
    m_idle = 1'b0;
    compare_all();
    $display("test idle done");

    b = 8'($urandom);
    b[3:0] = 4'h5;
    cmd(2, {8'h00, b, 8'hf6});
    m_en = 4'h5;
    compare_all();
    b = 8'($urandom);
    cmd(2, {8'h00, b, 8'hf4});
    m_lat = (m_lat & ~m_en) | (b[3:0] & m_en);
    repeat (3) @(negedge clk_in);
    compare_all();
    for (int c = 0; c < 4; c++) begin
      b = {4{c[1:0]}};
      cmd(2, {8'h00, b, 8'hf7});
      for (int n = 0; n < 4; n++) m_drv[n] = c[1:0];
      repeat (3) @(negedge clk_in);
      compare_all();
    end
    cmd(2, {8'h00, 8'h04, 8'hf6});
    m_en = 4'h4;
    cmd(2, {8'h00, 8'h05, 8'hf6});
    m_en = 4'h5;
    m_drv[0] = 2'h0;
    repeat (3) @(negedge clk_in);
    compare_all();
    $display("test pin setup done");

    ext_lvl = 4'($urandom);
    for (int n = 0; n < 4; n++)
      exp_pin[n] = f_oe(n) ? (m_en[n] ? m_lat[n] : spi_sel_n_in[n]) : ext_lvl[n];
    cmd(1, {16'h0000, 8'hf5});
    check(buf_wr_out, 1'b1);
    check(buf_data_out, {4'h0, exp_pin});
    host.message(1'b1, 0, 24'h000000);
    compare_all();
    $display("test pin sample done");
    finish_test();
  end

endmodule // tb_bridge_function_commands
